// *** design/fld_status_led.v ***
// Purpose: Drives the system, communication and fault lamps from device state.
// Assumes: Status inputs come from logic on sys_clk; software sets stages.
// Notes:   Lamps go dark during reset; every output is a flip-flop.
//          The divider runs free, so the first step after a change may lose one tick.
//          Boot stage code 3 leaves the system lamp dark.
//
// How it works
// - System lamp steady green while the operating system runs.
// - System lamp alternates green and yellow while the loader awaits firmware.
// - System lamp steady yellow while the ROM loader awaits the loader.
// - Communication lamp steady green in OPERATIONAL.
// - Communication lamp blinks green in PREOPERATIONAL.
// - Communication lamp single-flashes green in STOPPED.
// - Communication lamp off during reset or without configuration.
// - Slave auto baud detection flickers the communication lamp red and green.
// - Fault lamp single-flashes red at or above the warning level.
// - Fault lamp double-flashes red after a guarding or heartbeat event.
// - Fault lamp steady red while the controller is bus-off.
// - Fault lamp dark when no error is present.
// - Blinking is 200 ms on, 200 ms off, repeating.
// - Single flash is 200 ms on, then 1000 ms off.
// - Double flash is two 200 ms pulses, 200 ms gap, 1000 ms off.
// - Flickering is 50 ms on, 50 ms off, repeating.
`timescale 1ns/1ps
`include "fld_regs.vh"

module fld_status_led #(
    parameter [15:0] TICK_CYCLES = `FLD_TICK_CYCLES
) (
    // Clock, reset and enable
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wr_data,
    input  wire        reg_wr_en,
    input  wire        reg_rd_en,
    output reg  [31:0] reg_rd_data,
    // CAN controller status
    input  wire        can_warn,
    input  wire        can_bus_off,
    input  wire        guard_event,
    input  wire        hb_event,
    // Lamps
    output reg         sys_green,
    output reg         sys_yellow,
    output reg         comm_green,
    output reg         comm_red,
    output reg         fault_red
);

    // ============================================================
    // Declarations
    // ============================================================
    reg  [1:0]  boot_stage;
    reg  [1:0]  nmt_state;
    reg         slave_role;
    reg         autobaud;
    reg         ctrl_event;
    reg  [3:0]  lamp_test;
    reg  [15:0] tick_cnt;
    reg         ms_tick;
    reg  [2:0]  sys_pat;
    reg  [2:0]  comm_pat;
    reg  [2:0]  fault_pat;
    reg         next_sys_green;
    reg         next_sys_yellow;
    reg         next_comm_green;
    reg         next_comm_red;
    reg         next_fault_red;
    reg  [31:0] next_rd_data;
    reg  [1:0]  shown_stage;
    reg         shown_flicker;
    wire [8:0]  pat_bus;
    wire [2:0]  lit_bus;
    wire [5:0]  phase_bus;
    wire        wr_ctrl;
    wire        wr_event;
    wire        wr_test;
    wire        flicker_on;

    assign wr_ctrl  = reg_wr_en && (reg_addr == `FLD_CTRL_ADDR);
    assign wr_event = reg_wr_en && (reg_addr == `FLD_EVENT_ADDR);
    assign wr_test  = reg_wr_en && (reg_addr == `FLD_TEST_ADDR);

    // ============================================================
    // Register writes
    // ============================================================
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_stage <= `FLD_STAGE_ROM;
            nmt_state  <= `FLD_NMT_RESET;
            slave_role <= 1'b0;
            autobaud   <= 1'b0;
            lamp_test  <= 4'h0;
        end else if (clk_en) begin
            // A control write replaces all four fields at once.
            if (wr_ctrl) begin
                boot_stage <= reg_wr_data[`FLD_CTRL_STAGE_LSB +: 2];
                nmt_state  <= reg_wr_data[`FLD_CTRL_NMT_LSB +: 2];
                slave_role <= reg_wr_data[`FLD_CTRL_SLAVE_BIT];
                autobaud   <= reg_wr_data[`FLD_CTRL_BAUD_BIT];
            end
            // Lamp test bits are held until software next writes the test register.
            if (wr_test) begin
                lamp_test <= reg_wr_data[3:0];
            end
        end
    end

    // Error-control event flag: a new event in the clearing cycle wins,
    // so a guard or heartbeat loss is never hidden by a late clear.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_event <= 1'b0;
        end else if (clk_en) begin
            if (guard_event || hb_event) begin
                ctrl_event <= 1'b1;
            end else if (wr_event && reg_wr_data[0]) begin
                ctrl_event <= 1'b0;
            end
        end
    end

    // ============================================================
    // Register reads
    // ============================================================
    always @* begin
        next_rd_data = 32'h0000_0000;
        case (reg_addr)
            `FLD_CTRL_ADDR: begin
                next_rd_data[5:0] = {autobaud, slave_role, nmt_state, boot_stage};
            end
            `FLD_STATUS_ADDR: begin
                next_rd_data[4:0]   = {fault_red, comm_red, comm_green,
                                       sys_yellow, sys_green};
                next_rd_data[5]     = can_warn;
                next_rd_data[6]     = can_bus_off;
                next_rd_data[7]     = ctrl_event;
                next_rd_data[10:8]  = fault_pat;
                next_rd_data[13:11] = comm_pat;
                next_rd_data[16:14] = sys_pat;
                next_rd_data[22:17] = phase_bus;
            end
            `FLD_EVENT_ADDR: begin
                next_rd_data[0] = ctrl_event;
            end
            `FLD_TEST_ADDR: begin
                next_rd_data[3:0] = lamp_test;
            end
            // Unmapped addresses read as zero.
            default: begin
                next_rd_data = 32'h0000_0000;
            end
        endcase
    end

    // Read data is held only in the cycle after the strobe.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_data <= 32'h0000_0000;
        end else if (clk_en) begin
            if (reg_rd_en) begin
                reg_rd_data <= next_rd_data;
            end else begin
                reg_rd_data <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // Millisecond tick
    // ============================================================
    // One shared divider keeps all three lamps in step with each other.
    // A tick is one clock wide, so every generator sees it exactly once.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= 16'h0000;
            ms_tick  <= 1'b0;
        end else if (clk_en) begin
            if (tick_cnt == TICK_CYCLES - 16'h0001) begin
                tick_cnt <= 16'h0000;
                ms_tick  <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 16'h0001;
                ms_tick  <= 1'b0;
            end
        end
    end

    // ============================================================
    // Pattern selection
    // ============================================================
    always @* begin
        case (boot_stage)
            `FLD_STAGE_OS: sys_pat = `FLD_PAT_ON;
            `FLD_STAGE_LOADER: sys_pat = `FLD_PAT_BLINK;
            `FLD_STAGE_ROM: sys_pat = `FLD_PAT_ON;
            default: sys_pat = `FLD_PAT_OFF;
        endcase
    end

    // Flicker belongs to the slave role and then overrides the node state.
    assign flicker_on = slave_role && autobaud;

    always @* begin
        if (flicker_on) begin
            comm_pat = `FLD_PAT_FLICKER;
        end else begin
            case (nmt_state)
                `FLD_NMT_OPER: comm_pat = `FLD_PAT_ON;
                `FLD_NMT_PREOP: comm_pat = `FLD_PAT_BLINK;
                `FLD_NMT_STOPPED: comm_pat = `FLD_PAT_SINGLE;
                default: comm_pat = `FLD_PAT_OFF;
            endcase
        end
    end

    // A lower fault shows again as soon as a higher one clears, since
    // the selection is recomputed from the live inputs every cycle.
    always @* begin
        if (can_bus_off) begin
            fault_pat = `FLD_PAT_ON;
        end else if (ctrl_event) begin
            fault_pat = `FLD_PAT_DOUBLE;
        end else if (can_warn) begin
            fault_pat = `FLD_PAT_SINGLE;
        end else begin
            fault_pat = `FLD_PAT_OFF;
        end
    end

    assign pat_bus = {fault_pat, comm_pat, sys_pat};

    // ============================================================
    // Pattern generators
    // ============================================================
    // Index 0 drives the system lamp, 1 the communication lamp, 2 the fault lamp.
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : gen_lamp
            fld_pattern u_pat (
                .sys_clk   (sys_clk),
                .rst_b     (rst_b),
                .clk_en    (clk_en),
                .ms_tick   (ms_tick),
                .pattern   (pat_bus[3*ch +: 3]),
                .lit       (lit_bus[ch]),
                .phase_now (phase_bus[2*ch +: 2])
            );
        end
    endgenerate

    // ============================================================
    // Colour alignment
    // ============================================================
    // A generator loads a new pattern one edge after the selection moves.
    // The colour choice follows the same delayed copy, so a stale dark
    // step of the old pattern never shows one cycle of the second colour.
    // The output timing stays two cycles from the change.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            shown_stage   <= `FLD_STAGE_ROM;
            shown_flicker <= 1'b0;
        end else if (clk_en) begin
            shown_stage   <= boot_stage;
            shown_flicker <= flicker_on;
        end
    end

    // ============================================================
    // Lamp colours
    // ============================================================
    // The dark step of a two-colour pattern lights the second colour,
    // which gives the alternating green/yellow and red/green displays.
    always @* begin
        next_sys_green  = 1'b0;
        next_sys_yellow = 1'b0;
        case (shown_stage)
            `FLD_STAGE_OS: begin
                next_sys_green = lit_bus[0];
            end
            `FLD_STAGE_LOADER: begin
                next_sys_green  = lit_bus[0];
                next_sys_yellow = ~lit_bus[0];
            end
            `FLD_STAGE_ROM: begin
                next_sys_yellow = lit_bus[0];
            end
            default: begin
                next_sys_green = 1'b0;
            end
        endcase
        next_comm_green = lit_bus[1];
        next_comm_red   = shown_flicker & ~lit_bus[1];
        next_fault_red  = lit_bus[2];
        // Lamp test lets software check each lamp by eye during bring-up.
        if (lamp_test[`FLD_TEST_EN_BIT]) begin
            next_sys_green  = lamp_test[`FLD_TEST_SYS_BIT];
            next_sys_yellow = 1'b0;
            next_comm_green = lamp_test[`FLD_TEST_COMM_BIT];
            next_comm_red   = 1'b0;
            next_fault_red  = lamp_test[`FLD_TEST_FAULT_BIT];
        end
    end

    // Registered lamps keep decode glitches off the pins.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_green  <= 1'b0;
            sys_yellow <= 1'b0;
            comm_green <= 1'b0;
            comm_red   <= 1'b0;
            fault_red  <= 1'b0;
        end else if (clk_en) begin
            sys_green  <= next_sys_green;
            sys_yellow <= next_sys_yellow;
            comm_green <= next_comm_green;
            comm_red   <= next_comm_red;
            fault_red  <= next_fault_red;
        end
    end

endmodule

// *** design/fld_regs.vh ***
// Purpose: Shared constants for the fieldbus status lamp driver.
// Assumes: 40 MHz system clock and a 32-bit register port.
// Notes:   Definitions only; included by bare name.
`ifndef FLD_REGS_VH
`define FLD_REGS_VH

// ============================================================
// Register offsets
// ============================================================
`define FLD_CTRL_ADDR       8'h00
`define FLD_STATUS_ADDR     8'h04
`define FLD_EVENT_ADDR      8'h08
`define FLD_TEST_ADDR       8'h0C

// ============================================================
// Control register fields and reset value
// ============================================================
`define FLD_CTRL_STAGE_LSB  0
`define FLD_CTRL_NMT_LSB    2
`define FLD_CTRL_SLAVE_BIT  4
`define FLD_CTRL_BAUD_BIT   5
`define FLD_CTRL_RESET      6'h00

// Boot stage codes.
`define FLD_STAGE_ROM       2'h0
`define FLD_STAGE_LOADER    2'h1
`define FLD_STAGE_OS        2'h2

// Node management state codes.
`define FLD_NMT_RESET       2'h0
`define FLD_NMT_PREOP       2'h1
`define FLD_NMT_OPER        2'h2
`define FLD_NMT_STOPPED     2'h3

// ============================================================
// Lamp test register fields
// ============================================================
`define FLD_TEST_EN_BIT     0
`define FLD_TEST_SYS_BIT    1
`define FLD_TEST_COMM_BIT   2
`define FLD_TEST_FAULT_BIT  3

// ============================================================
// Pattern codes
// ============================================================
`define FLD_PAT_OFF         3'h0
`define FLD_PAT_ON          3'h1
`define FLD_PAT_BLINK       3'h2
`define FLD_PAT_FLICKER     3'h3
`define FLD_PAT_SINGLE      3'h4
`define FLD_PAT_DOUBLE      3'h5

// ============================================================
// Timing
// ============================================================
`define FLD_CLK_KHZ         40000
`define FLD_TICK_MS         1
// Clock cycles per 1 ms tick at the 40 MHz clock.
`define FLD_TICK_CYCLES     16'h9C40
`define FLD_FLASH_MS        200
`define FLD_LONG_OFF_MS     1000
`define FLD_FLICKER_MS      50
// Step lengths in 1 ms ticks, sized to the generators' 11-bit step counter.
`define FLD_FLASH_TICKS     11'h0C8
`define FLD_LONG_OFF_TICKS  11'h3E8
`define FLD_FLICKER_TICKS   11'h032

`endif

// *** design/fld_pattern.v ***
// Purpose: One lamp pattern generator paced by a millisecond tick.
// Assumes: ms_tick is a one-cycle pulse from the same clock.
// Notes:   Except in the steady on and off patterns, phase 0 is a lit step and odd phases are dark.
`timescale 1ns/1ps
`include "fld_regs.vh"

module fld_pattern (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    // Timing and selection
    input  wire       ms_tick,
    input  wire [2:0] pattern,
    // Result
    output wire       lit,
    output wire [1:0] phase_now
);

    reg  [2:0]  cur_pat;
    reg  [1:0]  phase;
    reg  [10:0] count;
    wire [10:0] step_len;
    wire [1:0]  last_phase;

    // ============================================================
    // Step lengths
    // ============================================================
    function [10:0] dur;
        input [2:0] pat;
        input [1:0] ph;
        begin
            if (pat == `FLD_PAT_FLICKER) begin
                dur = `FLD_FLICKER_TICKS;
            end else if (pat == `FLD_PAT_SINGLE && ph == 2'h1) begin
                dur = `FLD_LONG_OFF_TICKS;
            end else if (pat == `FLD_PAT_DOUBLE && ph == 2'h3) begin
                dur = `FLD_LONG_OFF_TICKS;
            end else begin
                dur = `FLD_FLASH_TICKS;
            end
        end
    endfunction

    assign step_len   = dur(cur_pat, phase);
    assign last_phase = (cur_pat == `FLD_PAT_DOUBLE) ? 2'h3 : 2'h1;

    // ============================================================
    // Phase sequencer
    // ============================================================
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_pat <= `FLD_PAT_OFF;
            phase   <= 2'h0;
            count   <= 11'h000;
        end else if (clk_en) begin
            if (pattern != cur_pat) begin
                cur_pat <= pattern;
                phase   <= 2'h0;
                count   <= 11'h000;
            end else if (ms_tick) begin
                if (count == step_len - 11'h001) begin
                    count <= 11'h000;
                    if (phase == last_phase) begin
                        phase <= 2'h0;
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end else begin
                    count <= count + 11'h001;
                end
            end
        end
    end

    assign lit = (cur_pat == `FLD_PAT_ON) ? 1'b1 :
                 (cur_pat == `FLD_PAT_OFF) ? 1'b0 : ~phase[0];
    assign phase_now = phase;

endmodule

// *** bench/fld_lamp_model.sv ***
// Purpose: Lamp observer that times the lit and dark runs of one lamp.
// Assumes: The lamp is sampled on sys_clk; clr discards the run in progress.
// Notes:   Only whole runs are reported, so a partial run never skews a length.
`timescale 1ns/1ps

module fld_lamp_model (
    // Clock and control
    input  wire sys_clk,
    input  wire clr,
    // Observed lamp
    input  wire lamp,
    // Run lengths in clock cycles
    output int  on_len,
    output int  off_len,
    output int  off_prev
);
    int   run;
    logic valid;
    logic last;

    always @(posedge sys_clk) begin
        last <= lamp;
        if (clr) begin
            run <= 0;
            valid <= 1'b0;
            on_len <= 0;
            off_len <= 0;
            off_prev <= 0;
        end else if (lamp !== last) begin
            if (valid && last) begin
                on_len <= run;
            end
            if (valid && !last) begin
                off_len <= run;
                off_prev <= off_len;
            end
            valid <= 1'b1;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
endmodule

// *** bench/fld_status_led_properties.sv ***
// Purpose: Concurrent checks on the ports of the status lamp driver.
// Assumes: clk_en drops and the lamp test runs only while no flash is timed.
// Notes:   Bound to every instance of fld_status_led.
`timescale 1ns/1ps

module fld_status_led_properties #(
    parameter [15:0] TICK_CYCLES = 16'h9C40
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        rst_b,
    input wire        clk_en,
    // Register port
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wr_data,
    input wire        reg_wr_en,
    input wire        reg_rd_en,
    input wire [31:0] reg_rd_data,
    // Status inputs
    input wire        can_warn,
    input wire        can_bus_off,
    input wire        guard_event,
    input wire        hb_event,
    // Lamps
    input wire        sys_green,
    input wire        sys_yellow,
    input wire        comm_green,
    input wire        comm_red,
    input wire        fault_red
);
    // ============================================================
    // Fault lamp run counter
    // ============================================================
    // The bound allows one divider tick of slack plus the selection pipeline.
    localparam int FLASH_MAX = 201 * TICK_CYCLES + 8;
    int   fr_run;
    logic warn_q;
    wire  cause = can_bus_off | guard_event | hb_event | reg_wr_en | (can_warn ^ warn_q);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fr_run <= 0;
            warn_q <= 1'b0;
        end else begin
            warn_q <= can_warn;
            fr_run <= (fault_red && !cause) ? fr_run + 1 : 0;
        end
    end

    // ============================================================
    // Properties
    // ============================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence rd_status;
        reg_rd_en && reg_addr == 8'h04;
    endsequence
    sequence rd_unmapped;
        reg_rd_en && reg_addr > 8'h0C;
    endsequence
    sequence busoff_held;
        can_bus_off [*3];
    endsequence

    a_comm_colour_excl: assert property (!(comm_green && comm_red))
        else $error("communication lamp shows both colours");
    a_sys_colour_excl: assert property (!(sys_green && sys_yellow))
        else $error("system lamp shows both colours");
    a_busoff_steady: assert property (busoff_held |-> fault_red)
        else $error("fault lamp dark during bus-off");
    a_flash_len_bound: assert property (fault_red |-> fr_run <= FLASH_MAX)
        else $error("fault lamp flash too long");
    a_reset_lamps_dark: assert property ($rose(rst_b) |->
        !(sys_green || sys_yellow || comm_green || comm_red || fault_red))
        else $error("lamp lit at reset release");
    a_boot_yellow: assert property ($rose(rst_b) |-> ##2 (sys_yellow && !sys_green))
        else $error("system lamp not yellow after reset");
    a_read_idle_zero: assert property (!$past(reg_rd_en) |-> reg_rd_data == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_read_unmapped: assert property (rd_unmapped |=> reg_rd_data == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_mirror: assert property (rd_status |=> reg_rd_data[6:0] == $past({can_bus_off,
        can_warn, fault_red, comm_red, comm_green, sys_yellow, sys_green}))
        else $error("status read differs from lamps");
endmodule

bind fld_status_led fld_status_led_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .can_warn(can_warn), .can_bus_off(can_bus_off),
    .guard_event(guard_event), .hb_event(hb_event), .sys_green(sys_green),
    .sys_yellow(sys_yellow), .comm_green(comm_green), .comm_red(comm_red),
    .fault_red(fault_red));

// *** bench/fld_status_led_tb.sv ***
// Purpose: Self-checking bench for the fieldbus status lamp driver.
// Assumes: A tick of 4 cycles, so 200 ms is 800 cycles.
// Notes:   Pattern lengths are timed by the lamp observer on whole runs only.
`timescale 1ns/1ps
`include "fld_regs.vh"

module fld_status_led_tb;
    localparam [15:0] TICK = 16'h0004;
    localparam int    F    = 200 * TICK;
    localparam int    L    = 1000 * TICK;
    logic        sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, clr = 1'b1;
    logic        reg_wr_en = 1'b0, reg_rd_en = 1'b0, guard_event = 1'b0, hb_event = 1'b0;
    logic        can_warn = 1'b0, can_bus_off = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wr_data = 32'h0000_0000, d;
    logic [1:0]  sel = 2'h0;
    wire  [31:0] reg_rd_data;
    wire         sys_green, sys_yellow, comm_green, comm_red, fault_red;
    wire  [4:0]  lamps = {fault_red, comm_red, comm_green, sys_yellow, sys_green};
    wire         lamp_pick = (sel == 2'h0) ? sys_green : (sel == 2'h1) ? comm_green : fault_red;
    int          on_len, off_len, off_prev, n_errors = 0, cmp_count = 0, cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    fld_status_led #(.TICK_CYCLES(TICK)) u_fld_status_led (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .can_warn(can_warn), .can_bus_off(can_bus_off),
        .guard_event(guard_event), .hb_event(hb_event), .sys_green(sys_green),
        .sys_yellow(sys_yellow), .comm_green(comm_green), .comm_red(comm_red),
        .fault_red(fault_red));

    fld_lamp_model u_fld_lamp_model (
        .sys_clk(sys_clk), .clr(clr), .lamp(lamp_pick),
        .on_len(on_len), .off_len(off_len), .off_prev(off_prev));

    // ============================================================
    // Tasks
    // ============================================================
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_en <= 1'b1;
        step(1);
        reg_wr_en <= 1'b0;
        step(1);
    endtask

    // Read data stand only in the cycle after the strobe, so look mid-cycle.
    task rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        step(1);
        reg_rd_en <= 1'b0;
        @(negedge sys_clk);
        v = reg_rd_data;
        step(1);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        check(d, e);
    endtask

    task lamp_is(input logic [4:0] e);
        step(4);
        @(negedge sys_clk);
        check({27'h0, lamps}, {27'h0, e});
        step(1);
    endtask

    task pulse_event(input logic hb);
        guard_event <= !hb;
        hb_event <= hb;
        step(1);
        guard_event <= 1'b0;
        hb_event <= 1'b0;
    endtask

    // The sum of two dark runs covers both the uniform and the double pattern.
    task meas(input logic [1:0] s, input int on_e, input int off_e, input int wt);
        sel <= s;
        clr <= 1'b1;
        step(1);
        clr <= 1'b0;
        step(wt);
        check(on_len, on_e);
        check(off_len + off_prev, off_e);
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            report_and_stop;
        end
    end

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        step(8);
        rst_b <= 1'b1;
        lamp_is(5'h02);
        rdc(`FLD_CTRL_ADDR, 32'h0000_0000);
        rdc(8'h10, 32'h0000_0000);
        wr(`FLD_TEST_ADDR, 32'h0000_000E);
        rdc(`FLD_TEST_ADDR, 32'h0000_000E);
        wr(`FLD_TEST_ADDR, 32'h0000_000F);
        lamp_is(5'h15);
        wr(`FLD_TEST_ADDR, 32'h0000_0000);
        wr(`FLD_CTRL_ADDR, 32'h0000_000A);
        lamp_is(5'h05);
        rd(`FLD_STATUS_ADDR, d);
        check(d & 32'h0001_FFFF, 32'h0000_4805);
        clk_en <= 1'b0;
        wr(`FLD_CTRL_ADDR, 32'h0000_0005);
        lamp_is(5'h05);
        clk_en <= 1'b1;
        rdc(`FLD_CTRL_ADDR, 32'h0000_000A);
        wr(`FLD_CTRL_ADDR, 32'h0000_0005);
        lamp_is(5'h05);
        step(F);
        lamp_is(5'h02);
        meas(2'h0, F, 2 * F, 6 * F);
        meas(2'h1, F, 2 * F, 6 * F);
        wr(`FLD_CTRL_ADDR, 32'h0000_000E);
        lamp_is(5'h05);
        meas(2'h1, F, 2 * L, 3 * (F + L));
        wr(`FLD_CTRL_ADDR, 32'h0000_0032);
        lamp_is(5'h05);
        step(F / 4);
        lamp_is(5'h09);
        meas(2'h1, F / 4, F / 2, 3 * F / 2);
        wr(`FLD_CTRL_ADDR, 32'h0000_0012);
        lamp_is(5'h01);
        can_warn <= 1'b1;
        lamp_is(5'h11);
        meas(2'h2, F, 2 * L, 3 * (F + L));
        pulse_event(1'b0);
        meas(2'h2, F, F + L, 3 * (3 * F + L));
        can_bus_off <= 1'b1;
        lamp_is(5'h11);
        step(L);
        lamp_is(5'h11);
        can_bus_off <= 1'b0;
        rdc(`FLD_EVENT_ADDR, 32'h0000_0001);
        wr(`FLD_EVENT_ADDR, 32'h0000_0001);
        can_warn <= 1'b0;
        pulse_event(1'b1);
        rdc(`FLD_EVENT_ADDR, 32'h0000_0001);
        wr(`FLD_EVENT_ADDR, 32'h0000_0001);
        rdc(`FLD_EVENT_ADDR, 32'h0000_0000);
        lamp_is(5'h01);
        step(F);
        lamp_is(5'h01);
        wr(`FLD_CTRL_ADDR, 32'h0000_0003);
        lamp_is(5'h00);
        report_and_stop;
    end
endmodule
